//--- verilog/embp_params.svh
// Constants for the external memory and I/O bus port
// Overview of operation
// - Data lines driven only on own writes
// - I/O request low during I/O accesses
// - Space requests undriven while reset active
// - Memory request low during memory accesses
// - Address and space requests are inputs when granted
// - Read strobe low for whole read
// - Write strobe low for whole write
// - Strobes and fetch flag float when granted
// - Fetch flag marks opcode reads from memory
// - Wait input low stretches the access
// - On request float bus, then acknowledge low
// - Reset pin is input and open-drain output
// - Own address lines driven while bus master
// - Chip select low inside its configured range
`ifndef EMBP_PARAMS_SVH
`define EMBP_PARAMS_SVH

// Bus widths
`define EMBP_ADDR_W 24
`define EMBP_DATA_W 8
`define EMBP_NUM_CS 4

// Clock rate in MHz
`define EMBP_CLK_MHZ 25

// Least self-reset pulse on the reset pin, in ns
`define EMBP_RST_PULSE_NS 640

// Reset values of the held access
`define EMBP_ADDR_RST 24'h000000
`define EMBP_DATA_RST 8'h00
`define EMBP_CNT_RST 16'h0000

`endif

//--- verilog/embp_pkg.sv
// Types for the external memory and I/O bus port
`include "embp_params.svh"

package embp_pkg;

    // Sequencer states of the bus port
    typedef enum logic [2:0] {
        EMBP_RESET,
        EMBP_IDLE,
        EMBP_ADDR,
        EMBP_STROBE,
        EMBP_FLOAT,
        EMBP_ACK,
        EMBP_RESUME
    } embp_state_t;

    // Whole state of the bus port
    typedef struct packed {
        embp_state_t st;
        logic [`EMBP_ADDR_W-1:0] addr;
        logic [`EMBP_DATA_W-1:0] wdata;
        logic write;
        logic io;
        logic fetch;
        logic [`EMBP_DATA_W-1:0] rdata;
        logic rsp_valid;
        logic [15:0] rst_cnt;
    } embp_regs_t;

    // Chip select levels of the decoder (unused; the bus view is combinational)
    typedef struct packed {
        logic [`EMBP_NUM_CS-1:0] cs_n;
    } embp_cs_regs_t;

endpackage

//--- verilog/embp_cs_if.sv
// Bus view shared between the port sequencer and the chip select decoder
`timescale 1ns/1ns
`include "embp_params.svh"

interface embp_cs_if;
    logic [`EMBP_ADDR_W-1:0] addr; // Address seen on the bus
    logic io_space_request_n;                  // I/O space request seen on the bus
    logic memory_space_request_n;                  // Memory space request seen on the bus
    logic [`EMBP_NUM_CS-1:0] cs_n; // Decoded chip selects

    // Sequencer side
    modport port (output addr, output io_space_request_n, output memory_space_request_n, input cs_n);
    // Decoder side
    modport decoder (input addr, input io_space_request_n, input memory_space_request_n, output cs_n);
endinterface

//--- verilog/embp_chip_select.sv
// Chip select decoder: one active-low line per configured range
`timescale 1ns/1ns
`include "embp_params.svh"

module embp_chip_select #(
    parameter int NUM_CS = `EMBP_NUM_CS
) (
    embp_cs_if.decoder bus,
    input wire logic [NUM_CS-1:0] cs_enable,
    input wire logic [NUM_CS-1:0] cs_is_io,
    input wire logic [NUM_CS-1:0][`EMBP_ADDR_W-1:0] cs_lower,
    input wire logic [NUM_CS-1:0][`EMBP_ADDR_W-1:0] cs_upper
);

    // Inclusive range test, shared by every line
    function automatic logic in_range(
        input logic [`EMBP_ADDR_W-1:0] a,
        input logic [`EMBP_ADDR_W-1:0] lo,
        input logic [`EMBP_ADDR_W-1:0] hi
    );
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // One decoder per line; lower numbered line wins on overlap
    genvar i;
    generate
        for (i = 0; i < NUM_CS; i++) begin : g_cs
            logic space_hit; // Access in this line's space
            logic lower_hit; // A lower line already selected
            assign space_hit = cs_is_io[i] ? !bus.io_space_request_n : !bus.memory_space_request_n;
            if (i == 0) begin : g_first
                assign lower_hit = 1'b0;
            end else begin : g_rest
                assign lower_hit = g_cs[i-1].lower_hit || !bus.cs_n[i-1];
            end
            // Line low while an access falls in its range
            assign bus.cs_n[i] = !(cs_enable[i] && space_hit && !lower_hit
                && in_range(bus.addr, cs_lower[i], cs_upper[i]));
        end
    endgenerate

endmodule

//--- verilog/embp_bus_port.sv
// External memory and I/O bus port: sequencer, bus release and reset pin
`timescale 1ns/1ns
`include "embp_params.svh"

module embp_bus_port #(
    parameter int NUM_CS = `EMBP_NUM_CS,
    parameter int RST_PULSE_CYC =
        (`EMBP_RST_PULSE_NS * `EMBP_CLK_MHZ + 999) / 1000
) (
    input wire logic clk,
    input wire logic reset_n,
    // Access requests from the core
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_io,
    input wire logic req_fetch,
    input wire logic [`EMBP_ADDR_W-1:0] req_addr,
    input wire logic [`EMBP_DATA_W-1:0] req_wdata,
    output logic rsp_valid,
    output logic [`EMBP_DATA_W-1:0] rsp_rdata,
    // Core asks to reset itself
    input wire logic self_reset_req,
    // Device held in reset by the pin
    output logic in_reset,
    // Chip select range configuration
    input wire logic [NUM_CS-1:0] cs_enable,
    input wire logic [NUM_CS-1:0] cs_is_io,
    input wire logic [NUM_CS-1:0][`EMBP_ADDR_W-1:0] cs_lower,
    input wire logic [NUM_CS-1:0][`EMBP_ADDR_W-1:0] cs_upper,
    // Address pins
    input wire logic [`EMBP_ADDR_W-1:0] addr_in,
    output logic [`EMBP_ADDR_W-1:0] addr_out,
    output logic addr_oe_n,
    // Data pins
    input wire logic [`EMBP_DATA_W-1:0] data_in,
    output logic [`EMBP_DATA_W-1:0] data_out,
    output logic data_oe_n,
    // I/O space request pin
    input wire logic io_space_request_n_in,
    output logic io_space_request_n_out,
    output logic io_space_request_oe_n,
    // Memory space request pin
    input wire logic memory_space_request_n_in,
    output logic memory_space_request_n_out,
    output logic memory_space_request_oe_n,
    // Read and write strobes
    output logic read_strobe_n,
    output logic read_strobe_oe_n,
    output logic write_strobe_n,
    output logic write_strobe_oe_n,
    // Instruction fetch flag
    output logic instruction_fetch_flag,
    output logic instruction_fetch_flag_oe_n,
    // Wait input
    input wire logic wait_n,
    // Bus release handshake
    input wire logic bus_release_request_n,
    output logic bus_grant_ack_n,
    // Chip selects
    output logic [NUM_CS-1:0] chip_select_lines_n,
    // Open-drain reset pin
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe_n
);

    // Self-reset length in clocks; the default
    // rounds the pulse time up to whole clocks
    localparam logic [15:0] RST_PULSE = 16'(RST_PULSE_CYC); // Self-reset length

    embp_pkg::embp_regs_t state_q; // Registered state
    embp_pkg::embp_regs_t state_d; // Next state
    embp_cs_if cs_bus ();          // Bus view for the decoder

    logic owner;    // Port drives address and control
    logic busy_st;  // Access in progress
    logic pin_low;  // Reset pin reads low

    // RESET, FLOAT and ACK leave every pin floated
    // Decode of the current state
    always_comb begin
        owner = (state_q.st == embp_pkg::EMBP_IDLE)
            || (state_q.st == embp_pkg::EMBP_ADDR)
            || (state_q.st == embp_pkg::EMBP_STROBE)
            || (state_q.st == embp_pkg::EMBP_RESUME);
        busy_st = (state_q.st == embp_pkg::EMBP_ADDR)
            || (state_q.st == embp_pkg::EMBP_STROBE);
        pin_low = !reset_pin_in;
    end

    // Access walk, one line per clock:
    // Taking edge: request copied, go to ADDR
    // ADDR: address and any write data driven
    // STROBE: space request and strobe low
    // STROBE again while wait reads low
    // IDLE again: strobes high, answer pulse
    // Release walk, one line per clock:
    // Request low seen in IDLE: go to FLOAT
    // FLOAT: every pin floated, no acknowledge yet
    // ACK: acknowledge low until request is high
    // RESUME: idle levels driven, acknowledge high
    // Request withdrawn in FLOAT skips ACK
    // Pin reset aborts an access with no answer
    // Next-state logic of the whole port
    always_comb begin
        state_d = state_q;
        // Answer pulse lasts one clock
        state_d.rsp_valid = 1'b0;
        // Self-reset pulse counts down while the pin is pulled
        if (self_reset_req && state_q.rst_cnt == 16'h0000) begin
            state_d.rst_cnt = RST_PULSE;
        end else if (state_q.rst_cnt != 16'h0000) begin
            state_d.rst_cnt = state_q.rst_cnt - 16'h0001;
        end
        // Pin low wins over every state below
        if (pin_low) begin
            // External or own low on the pin aborts everything
            state_d.st = embp_pkg::EMBP_RESET;
        end else begin
            case (state_q.st)
                // Leave reset once the pin is high again
                embp_pkg::EMBP_RESET: begin
                    state_d.st = embp_pkg::EMBP_IDLE;
                end
                // Release takes priority over a new access
                embp_pkg::EMBP_IDLE: begin
                    if (!bus_release_request_n) begin
                        state_d.st = embp_pkg::EMBP_FLOAT;
                    end else if (req_valid) begin
                        state_d.st = embp_pkg::EMBP_ADDR;
                        state_d.addr = req_addr;
                        state_d.wdata = req_wdata;
                        state_d.write = req_write;
                        state_d.io = req_io;
                        state_d.fetch = req_fetch && !req_io && !req_write;
                    end
                end
                // Address settles before the strobes fall
                embp_pkg::EMBP_ADDR: begin
                    state_d.st = embp_pkg::EMBP_STROBE;
                end
                // Strobe phase, stretched while wait is low
                embp_pkg::EMBP_STROBE: begin
                    if (wait_n) begin
                        state_d.st = embp_pkg::EMBP_IDLE;
                        state_d.rsp_valid = 1'b1;
                        if (!state_q.write) begin
                            state_d.rdata = data_in;
                        end
                    end
                end
                // Bus floated; acknowledge follows one cycle later
                embp_pkg::EMBP_FLOAT: begin
                    state_d.st = bus_release_request_n
                        ? embp_pkg::EMBP_RESUME : embp_pkg::EMBP_ACK;
                end
                // Bus handed over until the request returns high
                embp_pkg::EMBP_ACK: begin
                    if (bus_release_request_n) begin
                        state_d.st = embp_pkg::EMBP_RESUME;
                    end
                end
                // Driving again with idle levels before any access
                embp_pkg::EMBP_RESUME: begin
                    state_d.st = embp_pkg::EMBP_IDLE;
                end
                default: begin
                    state_d.st = embp_pkg::EMBP_RESET;
                end
            endcase
        end
    end

    // Only flops of the port; every pin below
    // decodes them, so pin levels change right
    // after the deciding edge
    // State register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q.st <= embp_pkg::EMBP_RESET;
            state_q.addr <= `EMBP_ADDR_RST;
            state_q.wdata <= `EMBP_DATA_RST;
            state_q.write <= 1'b0;
            state_q.io <= 1'b0;
            state_q.fetch <= 1'b0;
            state_q.rdata <= `EMBP_DATA_RST;
            state_q.rsp_valid <= 1'b0;
            state_q.rst_cnt <= `EMBP_CNT_RST;
        end else begin
            state_q <= state_d;
        end
    end

    // Ready is combinational, so a held request
    // is taken on the first edge the port is free
    // Core-side handshake and answer
    always_comb begin
        req_ready = (state_q.st == embp_pkg::EMBP_IDLE)
            && bus_release_request_n && !pin_low;
        rsp_valid = state_q.rsp_valid;
        rsp_rdata = state_q.rdata;
        in_reset = (state_q.st == embp_pkg::EMBP_RESET);
    end

    // Address stays on the pins between accesses
    // Address pins: driven while master, inputs when granted
    always_comb begin
        addr_out = state_q.addr;
        addr_oe_n = !owner;
    end

    // Floated on reads so the memory or
    // peripheral can drive the lines back
    // Data pins: driven only during own write accesses
    always_comb begin
        data_out = state_q.wdata;
        data_oe_n = !(busy_st && state_q.write);
    end

    // Requests fall one clock after the address,
    // so decoders see a settled address
    // Space requests: low only in the strobe phase of the access
    always_comb begin
        io_space_request_n_out = !((state_q.st == embp_pkg::EMBP_STROBE)
            && state_q.io);
        memory_space_request_n_out = !((state_q.st == embp_pkg::EMBP_STROBE)
            && !state_q.io);
        // Undriven in reset and while granted
        io_space_request_oe_n = !owner;
        memory_space_request_oe_n = !owner;
    end

    // Fetch flag never set for I/O or writes
    // Read and write strobes and the fetch flag
    always_comb begin
        read_strobe_n = !((state_q.st == embp_pkg::EMBP_STROBE)
            && !state_q.write);
        write_strobe_n = !((state_q.st == embp_pkg::EMBP_STROBE)
            && state_q.write);
        // Flag rides with memory request and read strobe
        instruction_fetch_flag = (state_q.st == embp_pkg::EMBP_STROBE)
            && state_q.fetch;
        // Floated in reset and while granted
        read_strobe_oe_n = !owner;
        write_strobe_oe_n = !owner;
        instruction_fetch_flag_oe_n = !owner;
    end

    // High in FLOAT, so the outside master never
    // sees it before all pins have let go
    // Acknowledge low only while the bus is handed over
    always_comb begin
        bus_grant_ack_n = (state_q.st != embp_pkg::EMBP_ACK);
    end

    // Own pull loops back through the pin input,
    // so a self-reset also holds the port in RESET
    // Counter reloads only after the pulse ends
    // Reset pin: open drain, pulled low only during self-reset
    always_comb begin
        reset_pin_out = 1'b0;
        reset_pin_oe_n = (state_q.rst_cnt == 16'h0000);
    end

    // Own levels while driving, the outside
    // master's pin levels while granted
    // In RESET both requests read high, so no
    // select falls on a floating request pin
    // Bus view: own levels as master, pin levels when granted
    always_comb begin
        if (owner) begin
            cs_bus.addr = addr_out;
            cs_bus.io_space_request_n = io_space_request_n_out;
            cs_bus.memory_space_request_n = memory_space_request_n_out;
        end else if (state_q.st == embp_pkg::EMBP_RESET) begin
            cs_bus.addr = addr_in;
            cs_bus.io_space_request_n = 1'b1;
            cs_bus.memory_space_request_n = 1'b1;
        end else begin
            cs_bus.addr = addr_in;
            cs_bus.io_space_request_n = io_space_request_n_in;
            cs_bus.memory_space_request_n = memory_space_request_n_in;
        end
    end

    // More lines need a wider range configuration
    // Chip select decoder on the bus view
    embp_chip_select #(
        .NUM_CS(NUM_CS)
    ) u_cs (
        .bus(cs_bus.decoder),
        .cs_enable(cs_enable),
        .cs_is_io(cs_is_io),
        .cs_lower(cs_lower),
        .cs_upper(cs_upper)
    );

    // Chip select pins follow the decoder
    always_comb begin
        chip_select_lines_n = cs_bus.cs_n;
    end

endmodule

//--- verif/embp_mem_model.sv
// Behavioural memory and peripheral on the far side of the bus port
`timescale 1ns/1ns
`include "embp_params.svh"

module embp_mem_model #(
    parameter int WAITS = 2
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic slow,
    input wire logic [`EMBP_ADDR_W-1:0] addr,
    input wire logic [`EMBP_DATA_W-1:0] wdata,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    output logic [`EMBP_DATA_W-1:0] rdata,
    output logic wait_n
);
    logic [7:0] mem [256]; // Storage by low address byte
    logic [7:0] last_q; // Last byte returned
    int cnt_q; // Strobe cycles so far
    // Stall the first strobe cycles when slow
    assign wait_n = !(slow && (!read_strobe_n || !write_strobe_n) && cnt_q < WAITS);
    // Released bus shows the inverse of the last byte
    assign rdata = read_strobe_n ? ~last_q : mem[addr[7:0]];
    // Storage, stall count and last value
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 0;
            last_q <= 8'h00;
        end else if (!read_strobe_n || !write_strobe_n) begin
            cnt_q <= cnt_q + 1;
            if (!read_strobe_n) last_q <= mem[addr[7:0]];
            if (!write_strobe_n) mem[addr[7:0]] <= wdata;
        end else begin
            cnt_q <= 0;
        end
    end
    // Known contents
    initial for (int i = 0; i < 256; i++) mem[i] = 8'h00;
endmodule

//--- verif/embp_bus_port_asserts.sv
// Concurrent checks on the pins of the bus port
`timescale 1ns/1ns
`include "embp_params.svh"

module embp_bus_port_asserts #(
    parameter int NUM_CS = `EMBP_NUM_CS,
    parameter int RST_PULSE_CYC = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic addr_oe_n,
    input wire logic data_oe_n,
    input wire logic io_space_request_n_out,
    input wire logic io_space_request_oe_n,
    input wire logic memory_space_request_n_out,
    input wire logic memory_space_request_oe_n,
    input wire logic read_strobe_n,
    input wire logic read_strobe_oe_n,
    input wire logic write_strobe_n,
    input wire logic write_strobe_oe_n,
    input wire logic instruction_fetch_flag,
    input wire logic instruction_fetch_flag_oe_n,
    input wire logic wait_n,
    input wire logic bus_release_request_n,
    input wire logic bus_grant_ack_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Access taken, wait seen high or low in strobe phase
    sequence s_fast;
        req_valid && req_ready ##2 wait_n;
    endsequence
    sequence s_slow;
        req_valid && req_ready ##2 !wait_n;
    endsequence
    // Release asked from an idle port
    sequence s_release;
        req_ready && !req_valid ##1 !bus_release_request_n [*3];
    endsequence
    a_data_write_only: assert property (!data_oe_n |-> bus_grant_ack_n && read_strobe_n)
        else $error("data driven outside write");
    a_io_access_kind: assert property (!io_space_request_n_out && !io_space_request_oe_n
        |-> memory_space_request_n_out && (read_strobe_n ^ write_strobe_n))
        else $error("bad io access");
    a_mem_access_kind: assert property (!memory_space_request_n_out
        && !memory_space_request_oe_n
        |-> io_space_request_n_out && (read_strobe_n ^ write_strobe_n))
        else $error("bad memory access");
    a_grant_floats_all: assert property (!bus_grant_ack_n |-> addr_oe_n && data_oe_n
        && io_space_request_oe_n && memory_space_request_oe_n && read_strobe_oe_n
        && write_strobe_oe_n && instruction_fetch_flag_oe_n)
        else $error("pin driven while granted");
    a_fetch_marks_read: assert property (instruction_fetch_flag
        && !instruction_fetch_flag_oe_n |-> !memory_space_request_n_out && !read_strobe_n)
        else $error("fetch flag outside memory read");
    a_fast_complete: assert property (s_fast |=> rsp_valid)
        else $error("access not done in three cycles");
    a_wait_stretches: assert property (s_slow
        |=> !rsp_valid && (!read_strobe_n || !write_strobe_n))
        else $error("wait did not stretch");
    a_grant_timing: assert property (s_release |-> !bus_grant_ack_n)
        else $error("grant late");
    a_resume_drives: assert property (!bus_grant_ack_n && bus_release_request_n
        |=> bus_grant_ack_n && !addr_oe_n && !read_strobe_oe_n && read_strobe_n)
        else $error("no resume after release");
    a_idle_high: assert property (req_ready |-> read_strobe_n && write_strobe_n
        && io_space_request_n_out && memory_space_request_n_out && !read_strobe_oe_n)
        else $error("idle levels wrong");
endmodule

bind embp_bus_port embp_bus_port_asserts #(.NUM_CS(NUM_CS), .RST_PULSE_CYC(RST_PULSE_CYC)) u_chk (
    .clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .addr_oe_n(addr_oe_n), .data_oe_n(data_oe_n),
    .io_space_request_n_out(io_space_request_n_out),
    .io_space_request_oe_n(io_space_request_oe_n),
    .memory_space_request_n_out(memory_space_request_n_out),
    .memory_space_request_oe_n(memory_space_request_oe_n),
    .read_strobe_n(read_strobe_n), .read_strobe_oe_n(read_strobe_oe_n),
    .write_strobe_n(write_strobe_n), .write_strobe_oe_n(write_strobe_oe_n),
    .instruction_fetch_flag(instruction_fetch_flag),
    .instruction_fetch_flag_oe_n(instruction_fetch_flag_oe_n), .wait_n(wait_n),
    .bus_release_request_n(bus_release_request_n), .bus_grant_ack_n(bus_grant_ack_n));

//--- verif/tb_embp_bus_port.sv
// Self-checking testbench for the bus port
`timescale 1ns/1ns
`include "embp_params.svh"

module tb_embp_bus_port;
    localparam int PULSE = 3; // Shortened self-reset pulse
    logic clk = 0, reset_n = 0, req_valid = 0, req_write = 0, req_io = 0, req_fetch = 0;
    logic self_reset_req = 0, brr_n = 1, alt_io_n = 1, alt_mr_n = 1, slow = 0;
    logic [23:0] req_addr = 24'h0, alt_addr = 24'h0, addr_in, addr_out;
    logic [7:0] req_wdata = 8'h0, rsp_rdata, data_in, data_out;
    logic req_ready, rsp_valid, in_reset, addr_oe_n, data_oe_n, io_o, io_oe, mr_o, mr_oe;
    logic rs, rs_oe, ws, ws_oe, ff, ff_oe, wait_n, ack_n, rp_out, rp_oe_n;
    logic [3:0] cs_n, cs_en = 4'hf, cs_io = 4'ha;
    logic [3:0][23:0] cs_lo = {24'h0, 24'h80, 24'h10, 24'h0};
    logic [3:0][23:0] cs_hi = {24'hffffff, 24'hff, 24'h1f, 24'h7f};
    logic [7:0] shadow [256]; // Expected memory
    logic [31:0] seed = 32'h6cb82986;
    logic [23:0] corner [8] = '{24'h7f, 24'h80, 24'h10, 24'h1f, 24'hff, 24'h100, 24'h20, 24'h0};
    int n_errors = 0, n_compared = 0, n, m;
    // Alternate master drives pins only when the port floats them
    assign addr_in = addr_oe_n ? alt_addr : addr_out;
    always #20 clk = ~clk;
    embp_bus_port #(.RST_PULSE_CYC(PULSE)) dut (.clk(clk), .reset_n(reset_n),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_io(req_io),
        .req_fetch(req_fetch), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .self_reset_req(self_reset_req),
        .in_reset(in_reset), .cs_enable(cs_en), .cs_is_io(cs_io), .cs_lower(cs_lo),
        .cs_upper(cs_hi), .addr_in(addr_in), .addr_out(addr_out), .addr_oe_n(addr_oe_n),
        .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
        .io_space_request_n_in(io_oe ? alt_io_n : io_o), .io_space_request_n_out(io_o),
        .io_space_request_oe_n(io_oe), .memory_space_request_n_in(mr_oe ? alt_mr_n : mr_o),
        .memory_space_request_n_out(mr_o), .memory_space_request_oe_n(mr_oe),
        .read_strobe_n(rs), .read_strobe_oe_n(rs_oe), .write_strobe_n(ws),
        .write_strobe_oe_n(ws_oe), .instruction_fetch_flag(ff),
        .instruction_fetch_flag_oe_n(ff_oe), .wait_n(wait_n), .bus_release_request_n(brr_n),
        .bus_grant_ack_n(ack_n), .chip_select_lines_n(cs_n),
        .reset_pin_in(rp_oe_n ? 1'b1 : rp_out), .reset_pin_out(rp_out),
        .reset_pin_oe_n(rp_oe_n));
    embp_mem_model mem (.clk(clk), .reset_n(reset_n), .slow(slow), .addr(addr_out),
        .wdata(data_out), .read_strobe_n(rs | rs_oe), .write_strobe_n(ws | ws_oe),
        .rdata(data_in), .wait_n(wait_n));
    // Next pseudo-random word
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // Expected selects, lower index wins
    function automatic logic [3:0] exp_cs(input logic io, input logic [23:0] a);
        exp_cs = 4'hf;
        for (int i = 3; i >= 0; i--) begin
            if (cs_en[i] && cs_io[i] == io && a >= cs_lo[i] && a <= cs_hi[i]) exp_cs = ~(4'h1 << i);
        end
    endfunction
    // Compare and count
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    // One core access with pin checks in the strobe phase
    task automatic access(input logic w, io, f, input logic [23:0] a, input logic [7:0] d,
                          input int waits);
        int k;
        @(posedge clk);
        {req_valid, req_write, req_io, req_fetch, req_addr, req_wdata} <= {1'b1, w, io, f, a, d};
        slow <= (waits != 0);
        k = 0;
        @(negedge clk);
        while (req_ready !== 1'b1 && k < 50) begin
            @(negedge clk);
            k++;
        end
        @(posedge clk);
        req_valid <= 1'b0;
        k = 0;
        do begin
            @(negedge clk);
            k++;
            if (rs === 1'b0 || ws === 1'b0) begin
                chk("addr", a, addr_out);
                chk("space", {!io, io}, {io_o, mr_o});
                chk("strobes", {w, !w}, {rs, ws});
                chk("fetch", f && !io && !w, ff);
                chk("data_oe", !w, data_oe_n);
                if (w) chk("wdata", d, data_out);
                chk("cs", exp_cs(io, a), cs_n);
            end
        end while (rsp_valid !== 1'b1 && k < 50);
        chk("latency", 3 + waits, k);
        chk("idle", 4'hf, {rs, ws, io_o, mr_o});
        if (w) shadow[a[7:0]] = d;
        else chk("rdata", shadow[a[7:0]], rsp_rdata);
    endtask
    // Verdict
    task automatic tally_and_finish();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        for (int i = 0; i < 256; i++) shadow[i] = 8'h00;
        repeat (11) @(posedge clk);
        @(negedge clk);
        chk("rst_float", 3'h7, {in_reset, io_oe, mr_oe});
        @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 8; i++) access(i[1], i[0], i[2], corner[i], 8'(i * 37 + 5), 0);
        repeat (40) begin
            seed = xs(seed);
            access(seed[0], seed[1], seed[2], {15'h0, seed[3], seed[15:8]}, seed[23:16],
                   seed[4] ? 2 : 0);
        end
        @(posedge clk);
        {brr_n, alt_addr, alt_io_n} <= {1'b0, 24'h15, 1'b0};
        n = 0;
        @(negedge clk);
        while (ack_n !== 1'b0 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk("grant_lat", 2, n);
        chk("float", 7'h7f, {addr_oe_n, data_oe_n, io_oe, mr_oe, rs_oe, ws_oe, ff_oe});
        chk("refuse", 1'b0, req_ready);
        chk("cs_alt", 4'hd, cs_n);
        @(posedge clk);
        {brr_n, alt_io_n} <= 2'h3;
        @(posedge clk);
        @(negedge clk);
        chk("resume", 2'h2, {ack_n, addr_oe_n});
        @(posedge clk);
        brr_n <= 1'b0;
        @(posedge clk);
        brr_n <= 1'b1;
        @(negedge clk);
        chk("withdraw", 2'h3, {ack_n, addr_oe_n});
        @(negedge clk);
        chk("withdraw_end", 2'h2, {ack_n, addr_oe_n});
        @(posedge clk);
        self_reset_req <= 1'b1;
        @(posedge clk);
        self_reset_req <= 1'b0;
        n = 0;
        m = 0;
        repeat (PULSE + 6) begin
            @(negedge clk);
            n += !rp_oe_n;
            m += in_reset;
        end
        chk("pulse", PULSE, n);
        chk("held", PULSE, m);
        chk("pin_out", 1'b0, rp_out);
        access(1'b0, 1'b0, 1'b1, 24'h7f, 8'h00, 2);
        tally_and_finish();
    end
endmodule
